// ---- design/scc_pkg.sv ----
// Package of register map, field layout and carrier types for the clock control block
package scc_pkg;

	// ************************************************************
	// Register addresses on the serial port
	// ************************************************************
	localparam logic [14:0] ADDR_SYNC_CTRL = 15'h0029;
	localparam logic [14:0] ADDR_CLKIN_CTRL = 15'h002A;
	localparam logic [14:0] ADDR_NOISE_CTRL = 15'h002B;
	localparam logic [14:0] ADDR_EDGE_POS_B0 = 15'h002C;
	localparam logic [14:0] ADDR_EDGE_POS_B1 = 15'h002D;
	localparam logic [14:0] ADDR_EDGE_POS_B2 = 15'h002E;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] RST_SYNC_CTRL = 8'h80;
	localparam logic [7:0] RST_CLKIN_CTRL = 8'h00;
	localparam logic [7:0] RST_NOISE_CTRL = 8'h10;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int SYNC_PROC_EN_BIT = 6;
	localparam int SYNC_RECV_EN_BIT = 5;
	localparam int FINE_STEP_BIT = 4;
	localparam int DELAY_SEL_MSB = 3;
	localparam int DELAY_SEL_LSB = 0;
	localparam int SAMPLE_PECL_BIT = 2;
	localparam int SYNC_PECL_BIT = 1;
	localparam int POL_INVERT_BIT = 0;
	localparam int ANALOG_NS_BIT = 2;
	localparam int CLOCK_NS_BIT = 0;

	// ************************************************************
	// Serial frame layout: 1 read flag, 15 address bits, then data bytes
	// ************************************************************
	localparam logic [4:0] HDR_LAST_BIT = 5'h0F;
	localparam logic [4:0] BYTE_LAST_BIT = 5'h07;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic {
		SCC_PH_HEADER,
		SCC_PH_DATA
	} scc_phase_e;

	typedef struct packed {
		logic sync_event_processing_enable;
		logic sync_receiver_enable;
		logic window_fine_step;
		logic [3:0] capture_delay_select;
		logic sync_polarity_invert;
		logic sample_clock_pecl_mode;
		logic sync_input_pecl_mode;
		logic analog_rail_noise_suppress;
		logic clock_rail_noise_suppress;
	} scc_clk_cfg_s;

endpackage : scc_pkg

// ---- design/scc_sync_clock_control.sv ----
// Sync clock control registers behind the serial register port
`timescale 1ns/1ps
module scc_sync_clock_control (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Serial register port pins
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// Sync event path
	input wire logic sync_in,
	output logic sync_event,
	// Edge position detector result
	input wire logic [23:0] edge_position_status,
	// Settings to the analog clock path
	output scc_pkg::scc_clk_cfg_s clk_cfg
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic cs_n_m_ff, cs_n_s_ff, sclk_m_ff, sclk_s_ff, sclk_d_ff, sdi_m_ff, sdi_s_ff;
	logic sync_m_ff, sync_s_ff;
	logic [23:0] pos_m_ff, pos_s_ff;

	// Two flops on every pin; the pin side is asynchronous to clk_sys
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cs_n_m_ff <= 1'b1;
			cs_n_s_ff <= 1'b1;
			sclk_m_ff <= 1'b0;
			sclk_s_ff <= 1'b0;
			sclk_d_ff <= 1'b0;
			sdi_m_ff <= 1'b0;
			sdi_s_ff <= 1'b0;
			sync_m_ff <= 1'b0;
			sync_s_ff <= 1'b0;
			pos_m_ff <= 24'h000000;
			pos_s_ff <= 24'h000000;
		end else begin
			cs_n_m_ff <= spi_cs_n;
			cs_n_s_ff <= cs_n_m_ff;
			sclk_m_ff <= spi_sclk;
			sclk_s_ff <= sclk_m_ff;
			sclk_d_ff <= sclk_s_ff;
			sdi_m_ff <= spi_sdi;
			sdi_s_ff <= sdi_m_ff;
			sync_m_ff <= sync_in;
			sync_s_ff <= sync_m_ff;
			pos_m_ff <= edge_position_status;
			pos_s_ff <= pos_m_ff;
		end
	end

	logic [23:0] pos_d_ff, pos_hold_ff;

	// Status word crosses bit by bit and may tear; keep it only once two samples agree
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pos_d_ff <= 24'h000000;
			pos_hold_ff <= 24'h000000;
		end else begin
			pos_d_ff <= pos_s_ff;
			if (pos_s_ff == pos_d_ff)
				pos_hold_ff <= pos_s_ff;
		end
	end

	// ************************************************************
	// Register file
	// ************************************************************
	logic [7:0] sync_ctrl_ff, clkin_ctrl_ff, noise_ctrl_ff;

	// Read decode; unmapped addresses read zero
	function automatic logic [7:0] read_byte(input logic [14:0] addr,
		input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2,
		input logic [23:0] pos);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			scc_pkg::ADDR_SYNC_CTRL: val = r0;
			scc_pkg::ADDR_CLKIN_CTRL: val = r1;
			scc_pkg::ADDR_NOISE_CTRL: val = r2;
			scc_pkg::ADDR_EDGE_POS_B0: val = pos[7:0];
			scc_pkg::ADDR_EDGE_POS_B1: val = pos[15:8];
			scc_pkg::ADDR_EDGE_POS_B2: val = pos[23:16];
			default: val = 8'h00;
		endcase
		return val;
	endfunction : read_byte

	// ************************************************************
	// Serial frame engine
	// ************************************************************
	scc_pkg::scc_phase_e phase_ff;
	logic [4:0] bit_cnt_ff;
	logic [15:0] shift_in_ff;
	logic is_read_ff;
	logic [14:0] addr_ff;
	logic [7:0] dout_ff;
	logic sdo_ff;
	logic frame_active, sclk_rise, sclk_fall, hdr_done, byte_done, wr_strobe;
	logic [14:0] nxt_addr;
	logic [7:0] wr_data;

	// Edges seen on the synchronised clock; sclk must stay well below clk_sys/4
	assign frame_active = ~cs_n_s_ff;
	assign sclk_rise = frame_active & sclk_s_ff & ~sclk_d_ff;
	assign sclk_fall = frame_active & ~sclk_s_ff & sclk_d_ff;
	assign hdr_done = sclk_rise && phase_ff == scc_pkg::SCC_PH_HEADER
		&& bit_cnt_ff == scc_pkg::HDR_LAST_BIT;
	assign byte_done = sclk_rise && phase_ff == scc_pkg::SCC_PH_DATA
		&& bit_cnt_ff == scc_pkg::BYTE_LAST_BIT;
	assign wr_strobe = byte_done & ~is_read_ff;
	assign wr_data = {shift_in_ff[6:0], sdi_s_ff};
	// Address of the first byte at header end, else ascend for streaming
	assign nxt_addr = hdr_done ? {shift_in_ff[13:0], sdi_s_ff} : addr_ff + 15'h0001;

	// Phase and bit counting; chip select high aborts any partial frame
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			phase_ff <= scc_pkg::SCC_PH_HEADER;
			bit_cnt_ff <= 5'h00;
			shift_in_ff <= 16'h0000;
		end else if (!frame_active) begin
			phase_ff <= scc_pkg::SCC_PH_HEADER;
			bit_cnt_ff <= 5'h00;
		end else if (sclk_rise) begin
			shift_in_ff <= {shift_in_ff[14:0], sdi_s_ff};
			if (hdr_done || byte_done) begin
				phase_ff <= scc_pkg::SCC_PH_DATA;
				bit_cnt_ff <= 5'h00;
			end else begin
				bit_cnt_ff <= bit_cnt_ff + 5'h01;
			end
		end
	end

	// Command flag and address pointer
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			is_read_ff <= 1'b0;
			addr_ff <= 15'h0000;
		end else if (hdr_done) begin
			is_read_ff <= shift_in_ff[14];
			addr_ff <= nxt_addr;
		end else if (byte_done) begin
			addr_ff <= nxt_addr;
		end
	end

	// Read data: loaded at each byte boundary, shifted out on falling edges
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dout_ff <= 8'h00;
			sdo_ff <= 1'b0;
		end else if (hdr_done || byte_done) begin
			dout_ff <= read_byte(nxt_addr, sync_ctrl_ff, clkin_ctrl_ff, noise_ctrl_ff,
				pos_hold_ff);
		end else if (sclk_fall && phase_ff == scc_pkg::SCC_PH_DATA && is_read_ff) begin
			sdo_ff <= dout_ff[7];
			dout_ff <= {dout_ff[6:0], 1'b0};
		end
	end

	assign spi_sdo = sdo_ff;
	// Drive only while a read frame is in its data phase
	assign spi_sdo_oe = frame_active && phase_ff == scc_pkg::SCC_PH_DATA && is_read_ff;

	// Whole byte lands at once; reserved bits stored as written
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sync_ctrl_ff <= scc_pkg::RST_SYNC_CTRL;
			clkin_ctrl_ff <= scc_pkg::RST_CLKIN_CTRL;
			noise_ctrl_ff <= scc_pkg::RST_NOISE_CTRL;
		end else if (wr_strobe) begin
			if (addr_ff == scc_pkg::ADDR_SYNC_CTRL)
				sync_ctrl_ff <= wr_data;
			if (addr_ff == scc_pkg::ADDR_CLKIN_CTRL)
				clkin_ctrl_ff <= wr_data;
			if (addr_ff == scc_pkg::ADDR_NOISE_CTRL)
				noise_ctrl_ff <= wr_data;
		end
	end

	// ************************************************************
	// Settings to the analog path, straight from the register flops
	// ************************************************************
	assign clk_cfg.sync_event_processing_enable = sync_ctrl_ff[scc_pkg::SYNC_PROC_EN_BIT];
	assign clk_cfg.sync_receiver_enable = sync_ctrl_ff[scc_pkg::SYNC_RECV_EN_BIT];
	assign clk_cfg.window_fine_step = sync_ctrl_ff[scc_pkg::FINE_STEP_BIT];
	assign clk_cfg.capture_delay_select =
		sync_ctrl_ff[scc_pkg::DELAY_SEL_MSB:scc_pkg::DELAY_SEL_LSB];
	assign clk_cfg.sync_polarity_invert = clkin_ctrl_ff[scc_pkg::POL_INVERT_BIT];
	assign clk_cfg.sample_clock_pecl_mode = clkin_ctrl_ff[scc_pkg::SAMPLE_PECL_BIT];
	assign clk_cfg.sync_input_pecl_mode = clkin_ctrl_ff[scc_pkg::SYNC_PECL_BIT];
	assign clk_cfg.analog_rail_noise_suppress = noise_ctrl_ff[scc_pkg::ANALOG_NS_BIT];
	assign clk_cfg.clock_rail_noise_suppress = noise_ctrl_ff[scc_pkg::CLOCK_NS_BIT];

	// ************************************************************
	// Sync event processing
	// ************************************************************
	logic sync_lvl, sync_lvl_d_ff, sync_event_ff;

	// A disabled receiver delivers a steady low, so no events can leak through
	assign sync_lvl = clk_cfg.sync_receiver_enable
		& (sync_s_ff ^ clk_cfg.sync_polarity_invert);

	// One pulse per rising edge of the aligned sync level, only when processing
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sync_lvl_d_ff <= 1'b0;
			sync_event_ff <= 1'b0;
		end else begin
			sync_lvl_d_ff <= sync_lvl;
			sync_event_ff <= clk_cfg.sync_event_processing_enable
				& sync_lvl & ~sync_lvl_d_ff;
		end
	end

	assign sync_event = sync_event_ff;

endmodule : scc_sync_clock_control

// ---- tb/scc_host_model.sv ----
// Host model driving serial register frames
`timescale 1ns/1ps
module scc_host_model (
	// Clock
	input wire logic clk_sys,
	// Serial port
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe
);
	// Idle: deselected, clock low
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
	end
	// First n of 24 frame bits; five clocks a level leaves margin over three
	task automatic frame(input logic rd, input logic [14:0] adr, input logic [7:0] wd,
		input int n, output logic [7:0] rdat);
		logic [23:0] bits;
		if (!rd && adr == scc_pkg::ADDR_SYNC_CTRL) begin
			wd[7] = 1'b1;
		end
		bits = {rd, adr, wd};
		rdat = 8'h00;
		spi_cs_n <= 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			spi_sdi <= bits[i];
			repeat (5) @(posedge clk_sys);
			rdat = {rdat[6:0], spi_sdo_oe ? spi_sdo : 1'bx};
			spi_sclk <= 1'b1;
			repeat (5) @(posedge clk_sys);
			spi_sclk <= 1'b0;
		end
		// Hold select past the internal write; released data line toggles
		repeat (6) @(posedge clk_sys);
		spi_cs_n <= 1'b1;
		spi_sdi <= ~spi_sdi;
		repeat (5) @(posedge clk_sys);
	endtask : frame
endmodule : scc_host_model

// ---- tb/scc_sync_clock_control_monitor.sv ----
// Checker of the clock control block ports
`timescale 1ns/1ps
module scc_sync_clock_control_monitor (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Serial port
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe,
	// Sync path and settings
	input wire logic sync_in,
	input wire logic sync_event,
	input wire logic [23:0] edge_position_status,
	input wire scc_pkg::scc_clk_cfg_s clk_cfg
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// Events only possible with both enables set
	wire logic sync_live = clk_cfg.sync_event_processing_enable && clk_cfg.sync_receiver_enable;
	// ************
	// Properties
	// ************
	reset_fields_a: assert property ($fell(sys_rst) |-> clk_cfg == '0)
		else $error("settings not cleared by reset");
	proc_gate_a: assert property (sync_event |-> $past(clk_cfg.sync_event_processing_enable))
		else $error("event with processing off");
	recv_gate_a: assert property (sync_event |-> $past(clk_cfg.sync_receiver_enable))
		else $error("event with receiver off");
	event_single_a: assert property (sync_event |=> !sync_event)
		else $error("event longer than one cycle");
	rise_event_a: assert property ($rose(sync_in) && sync_live
		&& !clk_cfg.sync_polarity_invert |-> ##[2:6] sync_event)
		else $error("no event after rising sync");
	fall_event_a: assert property ($fell(sync_in) && sync_live
		&& clk_cfg.sync_polarity_invert |-> ##[2:6] sync_event)
		else $error("no event after inverted sync");
	cfg_hold_a: assert property (spi_cs_n [*6] |=> $stable(clk_cfg))
		else $error("settings changed outside a frame");
	oe_frame_a: assert property (spi_cs_n [*5] |-> !spi_sdo_oe)
		else $error("data out driven while deselected");
	sdo_shift_a: assert property (spi_sdo_oe && $past(spi_sdo_oe) && $changed(spi_sdo)
		|-> !spi_sclk)
		else $error("data out moved while serial clock high");
	// Main scenarios reached
	proc_on_c: cover property ($rose(clk_cfg.sync_event_processing_enable));
	event_c: cover property (sync_event);
	read_c: cover property ($rose(spi_sdo_oe));
endmodule : scc_sync_clock_control_monitor
bind scc_sync_clock_control scc_sync_clock_control_monitor mon_u (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
	.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sync_in(sync_in), .sync_event(sync_event),
	.edge_position_status(edge_position_status), .clk_cfg(clk_cfg));

// ---- tb/scc_sync_clock_control_test.sv ----
// Self-checking bench for the clock control registers
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module scc_sync_clock_control_test;
	// ************
	// Wiring
	// ************
	logic clk_sys, sys_rst, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, sync_in, sync_event;
	logic [23:0] edge_position_status;
	scc_pkg::scc_clk_cfg_s clk_cfg;
	int bad_count = 0;
	int cmp_count = 0;
	int ev_count = 0;
	int cyc = 0;
	logic [7:0] scratch;
	scc_sync_clock_control dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
		.sync_in(sync_in), .sync_event(sync_event),
		.edge_position_status(edge_position_status), .clk_cfg(clk_cfg));
	scc_host_model host_u (.clk_sys(clk_sys), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
	// 100 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Event counter and hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (sync_event === 1'b1) ev_count++;
		if (cyc == 10000) begin
			bad_count++;
			end_sim();
		end
	end
	// ************
	// Tasks
	// ************
	task automatic end_sim();
		if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic reg_wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] r;
		host_u.frame(1'b0, a, d, 24, r);
	endtask : reg_wr
	task automatic reg_rd(input logic [14:0] a, input logic [7:0] e);
		logic [7:0] r;
		host_u.frame(1'b1, a, 8'h00, 24, r);
		`CHK(r, e)
	endtask : reg_rd
	// Sync level held long enough for the synchroniser
	task automatic sync_step(input logic v);
		sync_in <= v;
		repeat (10) @(posedge clk_sys);
	endtask : sync_step
	// ************
	// Sequence
	// ************
	initial begin
		sys_rst = 1'b1;
		sync_in = 1'b0;
		edge_position_status = 24'hC3A51E;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk_sys);
		`CHK(clk_cfg, '0)
		reg_rd(scc_pkg::ADDR_SYNC_CTRL, 8'h80);
		reg_rd(scc_pkg::ADDR_CLKIN_CTRL, 8'h00);
		reg_rd(scc_pkg::ADDR_NOISE_CTRL, 8'h10);
		reg_wr(scc_pkg::ADDR_SYNC_CTRL, 8'hA0);
		`CHK(clk_cfg.sync_receiver_enable, 1'b1)
		sync_step(1'b1);
		sync_step(1'b0);
		`CHK(ev_count, 0)
		reg_wr(scc_pkg::ADDR_SYNC_CTRL, 8'hFA);
		`CHK({clk_cfg.window_fine_step, clk_cfg.capture_delay_select}, 5'h1A)
		reg_rd(scc_pkg::ADDR_SYNC_CTRL, 8'hFA);
		sync_step(1'b1);
		`CHK(ev_count, 1)
		reg_wr(scc_pkg::ADDR_CLKIN_CTRL, 8'h07);
		`CHK({clk_cfg.sync_polarity_invert, clk_cfg.sample_clock_pecl_mode,
			clk_cfg.sync_input_pecl_mode}, 3'b111)
		sync_step(1'b0);
		`CHK(ev_count, 2)
		reg_wr(scc_pkg::ADDR_NOISE_CTRL, 8'h15);
		`CHK({clk_cfg.analog_rail_noise_suppress,
			clk_cfg.clock_rail_noise_suppress}, 2'b11)
		reg_rd(scc_pkg::ADDR_NOISE_CTRL, 8'h15);
		reg_wr(scc_pkg::ADDR_EDGE_POS_B0, 8'h00);
		reg_rd(scc_pkg::ADDR_EDGE_POS_B0, 8'h1E);
		reg_rd(scc_pkg::ADDR_EDGE_POS_B1, 8'hA5);
		reg_rd(scc_pkg::ADDR_EDGE_POS_B2, 8'hC3);
		reg_rd(15'h0030, 8'h00);
		// Cut frame after four data bits must write nothing
		host_u.frame(1'b0, scc_pkg::ADDR_SYNC_CTRL, 8'h80, 20, scratch);
		reg_rd(scc_pkg::ADDR_SYNC_CTRL, 8'hFA);
		// Delay tap picked from the low status nibble, fine steps kept on
		reg_wr(scc_pkg::ADDR_SYNC_CTRL, {4'hF, edge_position_status[3:0]});
		`CHK(clk_cfg.capture_delay_select, edge_position_status[3:0])
		end_sim();
	end
endmodule : scc_sync_clock_control_test
